// [verilog/hfc_pkg.sv]
// Purpose: Shared constants for the frame transmit-control and receive-status block.
// Assumes: Registers sit behind a plain address/strobe port with 2-bit word addresses.
// Notes:   Serial bits go out least significant bit first; the check sequence is the reflected 16-bit CRC.
package hfc_pkg;

  // Register offsets.
  localparam logic [1:0]  ADDR_TX_CTRL  = 2'h0;
  localparam logic [1:0]  ADDR_RX_STAT  = 2'h1;
  localparam logic [1:0]  ADDR_LINE_CFG = 2'h2;

  // Transmit control bits.
  localparam int          TC_CLOSE_ON_UNDERRUN = 0;
  localparam int          TC_REQUEST_TO_SEND   = 1;
  localparam int          TC_DATA_INVERT       = 2;
  localparam int          TC_FRAME_CLOSE       = 3;
  localparam int          TC_ABORT_FLAG        = 4;
  localparam int          TC_IDLE_FILL         = 5;
  localparam int          TC_FAR_LOOP_TEST     = 6;
  localparam int          TC_NEAR_LOOP_TEST    = 7;
  localparam logic [7:0]  TX_CTRL_RESET        = 8'h20;

  // Receive status bits.
  localparam int          RS_QUEUE_STATE_LOW   = 0;
  localparam int          RS_QUEUE_STATE_HIGH  = 1;
  localparam int          RS_PARTIAL_BYTE      = 2;
  localparam int          RS_CRC_FAILED        = 3;
  localparam int          RS_CRC_PASSED        = 4;
  localparam int          RS_IDLE              = 5;
  localparam int          RS_ABORT             = 6;
  localparam int          RS_LOST_STATUS       = 7;
  localparam logic [7:0]  RX_STAT_RESET        = 8'h00;

  // Line configuration bits.
  localparam int          LC_HANDSHAKE_ENABLE  = 0;
  localparam int          LC_AUTO_CLEAR        = 1;
  localparam logic [1:0]  LINE_CFG_RESET       = 2'h0;

  // Queue state encodings.
  localparam logic [1:0]  QS_EMPTY             = 2'h0;
  localparam logic [1:0]  QS_ONE               = 2'h1;
  localparam logic [1:0]  QS_OVERRUN           = 2'h2;
  localparam logic [1:0]  QS_TWO_OR_MORE       = 2'h3;

  // Line octets, sent least significant bit first.
  localparam logic [7:0]  FLAG_OCTET           = 8'h7e;
  localparam logic [7:0]  IDLE_OCTET           = 8'hff;
  localparam logic [7:0]  ABORT_OCTET          = 8'hfe;

  // Line counts.
  localparam logic [3:0]  IDLE_ONES            = 4'hf;
  localparam logic [3:0]  FLAG_ONES            = 4'h6;
  localparam logic [3:0]  STUFF_ONES           = 4'h5;
  localparam logic [2:0]  TX_STUFF_ONES        = 3'h5;
  localparam logic [3:0]  OCTET_LAST           = 4'h7;
  localparam logic [3:0]  CRC_LAST             = 4'hf;
  localparam logic [2:0]  RX_DELAY_BITS        = 3'h7;
  localparam logic [1:0]  ABORT_MIN_BYTES      = 2'h3;
  localparam logic [2:0]  STATUS_MAX_LEFT      = 3'h2;

  // Check sequence.
  localparam logic [15:0] CRC_INIT             = 16'hffff;
  localparam logic [15:0] CRC_POLY             = 16'h8408;
  localparam logic [15:0] CRC_RESIDUE          = 16'hf0b8;

  typedef enum logic [2:0] {
    TX_FILL,
    TX_OPEN,
    TX_DATA,
    TX_CRC,
    TX_CLOSE,
    TX_ABORT
  } hfc_tx_state_t;

endpackage

// [verilog/hfc_crc16.sv]
// Purpose: Bit-serial reflected 16-bit CRC used by both directions of the framer.
// Assumes: One data bit per enable, least significant bit first.
// Notes:   Init wins over enable so a frame start never folds in a stale bit.
`timescale 1ns/1ps
module hfc_crc16 (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // Control
  input  wire logic        init_i,
  input  wire logic        en_i,
  input  wire logic        bit_i,
  // Result
  output logic [15:0]      crc_o
);

  logic [15:0] crc_q;

  always_ff @(posedge core_clk_i) begin
    if (rst_i || init_i) begin
      crc_q <= hfc_pkg::CRC_INIT;
    end else if (en_i) begin
      if (crc_q[0] ^ bit_i) begin
        crc_q <= (crc_q >> 1) ^ hfc_pkg::CRC_POLY;
      end else begin
        crc_q <= crc_q >> 1;
      end
    end
  end

  assign crc_o = crc_q;

endmodule

// [verilog/hfc_framer.sv]
// Purpose: Transmit control and receive status of a bit-oriented synchronous frame formatter.
// Assumes: Byte queues live outside; the transmit clock pin is sampled by the core clock.
// Notes:   Transmit bits change on the falling line clock edge, received bits are taken on the rising edge.
// How it works
// - Close-on-underrun ends frame with CRC and flag.
// - Request-to-send bit drives pin under handshake enable.
// - Invert bit inverts receive stream, and transmit stream outside far loop.
// - Frame close ends frame; CRC unless abort.
// - Frame close sticks; hardware clears after last byte.
// - Abort bit aborts frame; hardware clears at start.
// - Idle bit with empty queue sends all ones.
// - Every reset sets the idle-fill bit.
// - Idle bit clear sends flags between frames.
// - Far loop retransmits every received bit.
// - Near loop routes transmitted bits to receiver.
// - Status bits 1:0 encode receive queue state.
// - Partial byte flag on non-octet frame length.
// - CRC failed flag when two bytes remain.
// - CRC passed flag when two bytes remain.
// - Idle flag after fifteen consecutive ones.
// - Abort flag after three or more bytes.
// - Lost flag when status changes before read.
// - Status read clears frame-end interrupt, overrun.
`timescale 1ns/1ps
module hfc_framer (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // Register port
  input  wire logic [1:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [7:0]       reg_rdata_o,
  // Transmit queue
  input  wire logic [7:0]  tx_data_i,
  input  wire logic        tx_valid_i,
  output logic             tx_take_o,
  // Receive queue
  output logic [7:0]       rx_data_o,
  output logic             rx_push_o,
  input  wire logic [2:0]  rx_count_i,
  input  wire logic        rx_overrun_i,
  // Serial line
  input  wire logic        transmit_clock_i,
  input  wire logic        rxd_i,
  output logic             txd_o,
  output logic             rts_o,
  output logic             receive_frame_end_irq_o
);

  // Control registers.
  logic [7:0]  tc_q;
  logic [1:0]  cfg_q;
  logic        fc_clr;
  logic        abt_clr;
  logic        frame_done;

  // Line synchronisers and edges.
  logic        transmit_clock_s1_q;
  logic        transmit_clock_s2_q;
  logic        transmit_clock_d_q;
  logic        rxd_s1_q;
  logic        rxd_s2_q;
  logic        tx_edge;
  logic        rx_edge;

  // Transmit state.
  hfc_pkg::hfc_tx_state_t st_q;
  hfc_pkg::hfc_tx_state_t st_d;
  logic [15:0] sh_q;
  logic [3:0]  cnt_q;
  logic [3:0]  last_q;
  logic [2:0]  ones_q;
  logic        stuff;
  logic        byte_end;
  logic        abort_now;
  logic [15:0] tx_crc;
  logic [15:0] tx_crc_nx;
  logic        line_q;

  // Receive state.
  logic        rx_bit;
  logic [3:0]  rones_q;
  logic        in_frame_q;
  logic [6:0]  dly_q;
  logic [2:0]  dcnt_q;
  logic [7:0]  rsh_q;
  logic [2:0]  rbit_q;
  logic [1:0]  rbytes_q;
  logic        release_en;
  logic        release_bit;
  logic        rx_init;
  logic [15:0] rx_crc;
  logic        fe_ev_q;
  logic        fe_good_q;
  logic        fe_part_q;
  logic        idle_ev_q;
  logic        abort_ev_q;

  // Status.
  logic        fpend_q;
  logic        fgood_q;
  logic        part_q;
  logic        bad_q;
  logic        good_q;
  logic        idle_q;
  logic        abort_q;
  logic        lost_q;
  logic        ovr_q;
  logic        unread_q;
  logic        stat_rd;
  logic        any_ev;
  logic        fstat_set;
  logic [1:0]  qstate;
  logic [7:0]  stat_word;

  function automatic logic wr_hit(input logic [1:0] a);
    wr_hit = reg_wr_i && (reg_addr_i == a);
  endfunction

  // Line clock and data pass two flops before anything looks at them.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      transmit_clock_s1_q <= 1'b0;
      transmit_clock_s2_q <= 1'b0;
      transmit_clock_d_q  <= 1'b0;
      rxd_s1_q  <= 1'b1;
      rxd_s2_q  <= 1'b1;
    end else begin
      transmit_clock_s1_q <= transmit_clock_i;
      transmit_clock_s2_q <= transmit_clock_s1_q;
      transmit_clock_d_q  <= transmit_clock_s2_q;
      rxd_s1_q  <= rxd_i;
      rxd_s2_q  <= rxd_s1_q;
    end
  end

  assign tx_edge = transmit_clock_d_q && !transmit_clock_s2_q;
  assign rx_edge = !transmit_clock_d_q && transmit_clock_s2_q;

  // Frame close and abort can only be set by software; hardware clear loses to a same-cycle set.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      tc_q <= hfc_pkg::TX_CTRL_RESET;
    end else begin
      if (wr_hit(hfc_pkg::ADDR_TX_CTRL)) begin
        tc_q[hfc_pkg::TC_CLOSE_ON_UNDERRUN] <= reg_wdata_i[hfc_pkg::TC_CLOSE_ON_UNDERRUN];
        tc_q[hfc_pkg::TC_REQUEST_TO_SEND]   <= reg_wdata_i[hfc_pkg::TC_REQUEST_TO_SEND];
        tc_q[hfc_pkg::TC_DATA_INVERT]       <= reg_wdata_i[hfc_pkg::TC_DATA_INVERT];
        tc_q[hfc_pkg::TC_IDLE_FILL]         <= reg_wdata_i[hfc_pkg::TC_IDLE_FILL];
        tc_q[hfc_pkg::TC_FAR_LOOP_TEST]     <= reg_wdata_i[hfc_pkg::TC_FAR_LOOP_TEST];
        tc_q[hfc_pkg::TC_NEAR_LOOP_TEST]    <= reg_wdata_i[hfc_pkg::TC_NEAR_LOOP_TEST];
      end
      if (wr_hit(hfc_pkg::ADDR_TX_CTRL) && reg_wdata_i[hfc_pkg::TC_FRAME_CLOSE]) begin
        tc_q[hfc_pkg::TC_FRAME_CLOSE] <= 1'b1;
      end else if (fc_clr) begin
        tc_q[hfc_pkg::TC_FRAME_CLOSE] <= 1'b0;
      end
      if (wr_hit(hfc_pkg::ADDR_TX_CTRL) && reg_wdata_i[hfc_pkg::TC_ABORT_FLAG]) begin
        tc_q[hfc_pkg::TC_ABORT_FLAG] <= 1'b1;
      end else if (abt_clr) begin
        tc_q[hfc_pkg::TC_ABORT_FLAG] <= 1'b0;
      end
      if (frame_done && cfg_q[hfc_pkg::LC_AUTO_CLEAR] && cfg_q[hfc_pkg::LC_HANDSHAKE_ENABLE]
          && !wr_hit(hfc_pkg::ADDR_TX_CTRL)) begin
        tc_q[hfc_pkg::TC_REQUEST_TO_SEND] <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cfg_q <= hfc_pkg::LINE_CFG_RESET;
    end else if (wr_hit(hfc_pkg::ADDR_LINE_CFG)) begin
      cfg_q <= reg_wdata_i[1:0];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rts_o <= 1'b0;
    end else begin
      rts_o <= cfg_q[hfc_pkg::LC_HANDSHAKE_ENABLE] && tc_q[hfc_pkg::TC_REQUEST_TO_SEND];
    end
  end

  // Transmit sequencing. Stuffed zeros do not advance the bit count.
  always_comb begin
    stuff      = ((st_q == hfc_pkg::TX_DATA) || (st_q == hfc_pkg::TX_CRC)
                 || ((st_q == hfc_pkg::TX_CLOSE) && (cnt_q == 4'h0))) && (ones_q == hfc_pkg::TX_STUFF_ONES);
    byte_end   = !stuff && (cnt_q == last_q);
    abort_now  = tc_q[hfc_pkg::TC_ABORT_FLAG] && ((st_q == hfc_pkg::TX_OPEN) || (st_q == hfc_pkg::TX_DATA)
                 || (st_q == hfc_pkg::TX_CRC));
    st_d       = st_q;
    fc_clr     = 1'b0;
    frame_done = 1'b0;
    if (abort_now) begin
      st_d = hfc_pkg::TX_ABORT;
    end else if (byte_end) begin
      case (st_q)
        hfc_pkg::TX_OPEN, hfc_pkg::TX_DATA: begin
          if (tx_valid_i) begin
            st_d = hfc_pkg::TX_DATA;
          end else if (tc_q[hfc_pkg::TC_CLOSE_ON_UNDERRUN]) begin
            st_d   = hfc_pkg::TX_CRC;
            fc_clr = 1'b1;
          end else if (tc_q[hfc_pkg::TC_FRAME_CLOSE]) begin
            st_d   = hfc_pkg::TX_CRC;
            fc_clr = 1'b1;
          end else begin
            st_d = hfc_pkg::TX_ABORT;
          end
        end
        hfc_pkg::TX_CRC: begin
          st_d = hfc_pkg::TX_CLOSE;
        end
        default: begin
          frame_done = (st_q == hfc_pkg::TX_CLOSE) || (st_q == hfc_pkg::TX_ABORT);
          if (tc_q[hfc_pkg::TC_ABORT_FLAG]) begin
            st_d = hfc_pkg::TX_ABORT;
          end else if (tx_valid_i) begin
            st_d = hfc_pkg::TX_OPEN;
          end else begin
            st_d = hfc_pkg::TX_FILL;
          end
        end
      endcase
    end
    fc_clr     = tx_edge && fc_clr;
    frame_done = tx_edge && frame_done;
    abt_clr    = tx_edge && (abort_now || byte_end) && (st_d == hfc_pkg::TX_ABORT)
                 && tc_q[hfc_pkg::TC_ABORT_FLAG];
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_q      <= hfc_pkg::TX_FILL;
      sh_q      <= {8'h00, hfc_pkg::IDLE_OCTET};
      cnt_q     <= 4'h0;
      last_q    <= hfc_pkg::OCTET_LAST;
      ones_q    <= 3'h0;
      line_q    <= 1'b1;
      tx_take_o <= 1'b0;
    end else begin
      tx_take_o <= 1'b0;
      if (tx_edge) begin
        line_q <= stuff ? 1'b0 : sh_q[0];
        if (stuff) begin
          ones_q <= 3'h0;
        end else if ((st_q == hfc_pkg::TX_DATA || st_q == hfc_pkg::TX_CRC) && sh_q[0]) begin
          ones_q <= ones_q + 3'h1;
        end else begin
          ones_q <= 3'h0;
        end
        if (abort_now || byte_end) begin
          st_q   <= st_d;
          cnt_q  <= 4'h0;
          last_q <= (st_d == hfc_pkg::TX_CRC) ? hfc_pkg::CRC_LAST : hfc_pkg::OCTET_LAST;
          if (abort_now) begin
            ones_q <= 3'h0;
          end
          case (st_d)
            hfc_pkg::TX_FILL: begin
              sh_q <= {8'h00, tc_q[hfc_pkg::TC_IDLE_FILL] ? hfc_pkg::IDLE_OCTET : hfc_pkg::FLAG_OCTET};
            end
            hfc_pkg::TX_DATA: begin
              sh_q      <= {8'h00, tx_data_i};
              tx_take_o <= 1'b1;
            end
            hfc_pkg::TX_CRC: begin
              sh_q <= ~tx_crc_nx;
            end
            hfc_pkg::TX_ABORT: begin
              sh_q <= {8'h00, hfc_pkg::ABORT_OCTET};
            end
            default: begin
              sh_q <= {8'h00, hfc_pkg::FLAG_OCTET};
            end
          endcase
        end else if (!stuff) begin
          sh_q  <= sh_q >> 1;
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  end

  hfc_crc16 u_tx_crc (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .init_i     (tx_edge && byte_end && !abort_now && st_d == hfc_pkg::TX_OPEN),
    .en_i       (tx_edge && !stuff && st_q == hfc_pkg::TX_DATA),
    .bit_i      (sh_q[0]),
    .crc_o      (tx_crc)
  );

  // The last data bit leaves on the edge that loads the check sequence, so it is folded in here.
  assign tx_crc_nx = (st_q != hfc_pkg::TX_DATA) ? tx_crc
                   : (tx_crc[0] ^ sh_q[0]) ? ((tx_crc >> 1) ^ hfc_pkg::CRC_POLY) : (tx_crc >> 1);

  // Far loop passes the raw line straight through, so its own inversion never applies twice.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      txd_o <= 1'b1;
    end else if (tc_q[hfc_pkg::TC_FAR_LOOP_TEST]) begin
      txd_o <= rxd_s2_q;
    end else begin
      txd_o <= line_q ^ tc_q[hfc_pkg::TC_DATA_INVERT];
    end
  end

  assign rx_bit = (tc_q[hfc_pkg::TC_NEAR_LOOP_TEST] ? txd_o : rxd_s2_q) ^ tc_q[hfc_pkg::TC_DATA_INVERT];

  // Data bits wait seven places so a closing flag's leading bits never reach the queue.
  always_comb begin
    release_en  = 1'b0;
    release_bit = dly_q[6];
    rx_init     = rx_edge && !rx_bit && (rones_q == hfc_pkg::FLAG_ONES);
    if (rx_edge && in_frame_q && (dcnt_q == hfc_pkg::RX_DELAY_BITS)) begin
      release_en = rx_bit ? (rones_q < hfc_pkg::FLAG_ONES) : (rones_q < hfc_pkg::STUFF_ONES);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rones_q    <= 4'h0;
      in_frame_q <= 1'b0;
      dly_q      <= 7'h00;
      dcnt_q     <= 3'h0;
      rsh_q      <= 8'h00;
      rbit_q     <= 3'h0;
      rbytes_q   <= 2'h0;
      rx_data_o  <= 8'h00;
      rx_push_o  <= 1'b0;
      fe_ev_q    <= 1'b0;
      fe_good_q  <= 1'b0;
      fe_part_q  <= 1'b0;
      idle_ev_q  <= 1'b0;
      abort_ev_q <= 1'b0;
    end else begin
      rx_push_o  <= 1'b0;
      fe_ev_q    <= 1'b0;
      idle_ev_q  <= 1'b0;
      abort_ev_q <= 1'b0;
      if (rx_edge) begin
        if (rx_bit) begin
          if (rones_q != hfc_pkg::IDLE_ONES) begin
            rones_q <= rones_q + 4'h1;
          end
          if (rones_q == hfc_pkg::IDLE_ONES - 4'h1) begin
            idle_ev_q <= 1'b1;
          end
          if (rones_q == hfc_pkg::FLAG_ONES) begin
            in_frame_q <= 1'b0;
            abort_ev_q <= in_frame_q && (rbytes_q == hfc_pkg::ABORT_MIN_BYTES);
          end
        end else begin
          rones_q <= 4'h0;
        end
        if (rx_init) begin
          in_frame_q <= 1'b1;
          fe_ev_q    <= in_frame_q && (rbytes_q != 2'h0);
          fe_part_q  <= (rbit_q != 3'h0);
          fe_good_q  <= (rx_crc == hfc_pkg::CRC_RESIDUE);
          dcnt_q     <= 3'h0;
          rbit_q     <= 3'h0;
          rbytes_q   <= 2'h0;
        end else if (in_frame_q && (rx_bit ? rones_q < hfc_pkg::FLAG_ONES : rones_q < hfc_pkg::STUFF_ONES)) begin
          dly_q <= {dly_q[5:0], rx_bit};
          if (dcnt_q != hfc_pkg::RX_DELAY_BITS) begin
            dcnt_q <= dcnt_q + 3'h1;
          end
        end
        if (release_en) begin
          rsh_q  <= {release_bit, rsh_q[7:1]};
          rbit_q <= rbit_q + 3'h1;
          if (rbit_q == 3'h7) begin
            rx_data_o <= {release_bit, rsh_q[7:1]};
            rx_push_o <= 1'b1;
            if (rbytes_q != hfc_pkg::ABORT_MIN_BYTES) begin
              rbytes_q <= rbytes_q + 2'h1;
            end
          end
        end
      end
    end
  end

  hfc_crc16 u_rx_crc (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .init_i     (rx_init),
    .en_i       (release_en && !rx_init),
    .bit_i      (release_bit),
    .crc_o      (rx_crc)
  );

  // Receive status. Every sticky bit is cleared by a status read, but a same-cycle event wins.
  always_comb begin
    stat_rd   = reg_rd_i && (reg_addr_i == hfc_pkg::ADDR_RX_STAT);
    fstat_set = fpend_q && (rx_count_i <= hfc_pkg::STATUS_MAX_LEFT);
    any_ev    = fstat_set || idle_ev_q || abort_ev_q || rx_overrun_i;
    if (ovr_q) begin
      qstate = hfc_pkg::QS_OVERRUN;
    end else if (rx_count_i == 3'h0) begin
      qstate = hfc_pkg::QS_EMPTY;
    end else if (rx_count_i == 3'h1) begin
      qstate = hfc_pkg::QS_ONE;
    end else begin
      qstate = hfc_pkg::QS_TWO_OR_MORE;
    end
    stat_word = {lost_q, abort_q, idle_q, good_q, bad_q, part_q, qstate};
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      fpend_q <= 1'b0;
      fgood_q <= 1'b0;
    end else if (fe_ev_q) begin
      fpend_q <= 1'b1;
      fgood_q <= fe_good_q;
    end else if (fstat_set) begin
      fpend_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      {lost_q, abort_q, idle_q, good_q, bad_q, part_q} <= hfc_pkg::RX_STAT_RESET[7:2];
      ovr_q    <= 1'b0;
      unread_q <= 1'b0;
    end else begin
      part_q   <= (fe_ev_q && fe_part_q) || (part_q && !stat_rd);
      bad_q    <= (fstat_set && !fgood_q) || (bad_q && !stat_rd);
      good_q   <= (fstat_set && fgood_q) || (good_q && !stat_rd);
      idle_q   <= idle_ev_q || (idle_q && !stat_rd);
      abort_q  <= abort_ev_q || (abort_q && !stat_rd);
      ovr_q    <= rx_overrun_i || (ovr_q && !stat_rd);
      lost_q   <= (any_ev && unread_q) || (lost_q && !stat_rd);
      unread_q <= any_ev || (unread_q && !stat_rd);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      receive_frame_end_irq_o <= 1'b0;
    end else begin
      receive_frame_end_irq_o <= fstat_set || (receive_frame_end_irq_o && !stat_rd);
    end
  end

  // Transmit control is write-only, so it reads back as zero like any unmapped word.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (stat_rd) begin
      reg_rdata_o <= stat_word;
    end else if (reg_rd_i && (reg_addr_i == hfc_pkg::ADDR_LINE_CFG)) begin
      reg_rdata_o <= {6'h00, cfg_q};
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

endmodule

// [dv/hfc_framer_props.sv]
// Purpose: Port-level checks of the framer.
// Assumes: Register writes are mirrored here, since transmit_control cannot be read.
// Notes:   Fill checks wait 400 cycles so a closing or abort octet can drain.
`timescale 1ns/1ps
module hfc_framer_chk (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  // Register port
  input  wire logic [1:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_rdata_o,
  // Queues
  input  wire logic       tx_valid_i,
  input  wire logic [2:0] rx_count_i,
  input  wire logic       rx_overrun_i,
  // Line
  input  wire logic       rxd_i,
  input  wire logic       txd_o,
  input  wire logic       rts_o
);
  logic [7:0] tc_q;
  logic [1:0] lc_q;
  logic       ovr_q;
  logic [9:0] fcnt_q;
  logic [6:0] hi_q;
  logic       rd_st;
  logic       far_ok;
  logic [1:0] qs_exp;
  assign rd_st  = reg_rd_i && reg_addr_i == hfc_pkg::ADDR_RX_STAT;
  assign far_ok = tc_q[6] && !tc_q[7] && !tc_q[2];
  assign qs_exp = (rx_count_i == 3'h0) ? hfc_pkg::QS_EMPTY :
                  (rx_count_i == 3'h1) ? hfc_pkg::QS_ONE : hfc_pkg::QS_TWO_OR_MORE;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      tc_q <= hfc_pkg::TX_CTRL_RESET;
      lc_q <= hfc_pkg::LINE_CFG_RESET;
    end else if (reg_wr_i && reg_addr_i == hfc_pkg::ADDR_TX_CTRL) begin
      tc_q <= reg_wdata_i;
    end else if (reg_wr_i && reg_addr_i == hfc_pkg::ADDR_LINE_CFG) begin
      lc_q <= reg_wdata_i[1:0];
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (rst_i) ovr_q <= 1'b0;
    else if (rx_overrun_i) ovr_q <= 1'b1;
    else if (rd_st) ovr_q <= 1'b0;
  end
  // Any write restarts the settling count, because fill changes only at an octet boundary.
  always_ff @(posedge core_clk_i) begin
    if (rst_i || reg_wr_i || tx_valid_i || tc_q[6] || tc_q[7]) fcnt_q <= 10'h0;
    else if (fcnt_q != 10'h3ff) fcnt_q <= fcnt_q + 10'h1;
  end
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !txd_o) hi_q <= 7'h0;
    else if (hi_q != 7'h7f) hi_q <= hi_q + 7'h1;
  end
  property p_rts;
    !lc_q[1] && !$past(lc_q[1]) |-> rts_o == $past(lc_q[0] && tc_q[1]);
  endproperty
  a_rts: assert property (p_rts) else $error("rts pin wrong");
  property p_rdz;
    !$past(reg_rd_i) |-> reg_rdata_o == 8'h00;
  endproperty
  a_rdz: assert property (p_rdz) else $error("read data outside answer cycle");
  property p_qs;
    rd_st && !ovr_q && !rx_overrun_i |=> reg_rdata_o[1:0] == $past(qs_exp);
  endproperty
  a_qs: assert property (p_qs) else $error("queue state wrong");
  property p_ovr;
    rd_st && ovr_q |=> reg_rdata_o[1:0] == hfc_pkg::QS_OVERRUN;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not held");
  property p_rst;
    disable iff (1'b0) rst_i |=> txd_o && !rts_o;
  endproperty
  a_rst: assert property (p_rst) else $error("line not idle in reset");
  property p_far;
    (far_ok && $stable(rxd_i))[*8] ##1 (far_ok && $stable(rxd_i))[*8] ##1 (far_ok && $stable(rxd_i))[*8]
      |-> txd_o == rxd_i;
  endproperty
  a_far: assert property (p_far) else $error("far loop not copied");
  property p_fill;
    fcnt_q >= 10'h190 && tc_q[5] |-> txd_o == !tc_q[2];
  endproperty
  a_fill: assert property (p_fill) else $error("idle fill wrong");
  property p_flag;
    fcnt_q >= 10'h190 && !tc_q[5] && !tc_q[2] |-> hi_q < 7'h3c;
  endproperty
  a_flag: assert property (p_flag) else $error("flag fill has long ones run");
endmodule

bind hfc_framer hfc_framer_chk i_hfc_framer_chk (.core_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
  .reg_rd_i, .reg_rdata_o, .tx_valid_i, .rx_count_i, .rx_overrun_i, .rxd_i, .txd_o, .rts_o);

// [dv/hfc_line_model.sv]
// Purpose: Far station giving the line clock and receive data.
// Assumes: The line clock runs free, as a modem clock does.
// Notes:   Bits change on the falling clock edge, least significant first.
`timescale 1ns/1ps
module hfc_line_model (
  // Pattern
  input  wire logic [7:0] pat_i,
  // Line
  output logic            lclk_o,
  output logic            rxd_o
);
  logic [2:0] idx = 3'h0;
  initial begin
    lclk_o = 1'b0;
    rxd_o = 1'b0;
    #37;
    forever begin
      #200 lclk_o = 1'b1;
      #200 lclk_o = 1'b0;
      rxd_o = pat_i[idx];
      idx = idx + 3'h1;
    end
  end
endmodule

// [dv/testbench.sv]
// Purpose: Register and line test of the framer.
// Assumes: Line model clock of 400 ns.
// Notes:   Frames are looped back inside the block.
`timescale 1ns/1ps
module testbench;
  logic        clk, tx_take, rx_push, lclk, rxd, txd, rts, irq, f;
  logic        rst = 1'b1, wr = 1'b0, rd = 1'b0, tx_valid = 1'b0, rx_ovr = 1'b0;
  logic [1:0]  addr = 2'h0;
  logic [2:0]  rx_count = 3'h0;
  logic [7:0]  wdata = 8'h00, tx_data = 8'h00, pat = 8'h00, rdata, rx_data, v;
  logic [31:0] b;
  logic [7:0]  rxq[$];
  logic [7:0]  fc[3] = '{8'ha3, 8'ha8, 8'hb0};
  int          num_errors = 0, check_count = 0;
  hfc_framer i_hfc_framer (.core_clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .tx_data_i(tx_data), .tx_valid_i(tx_valid),
    .tx_take_o(tx_take), .rx_data_o(rx_data), .rx_push_o(rx_push), .rx_count_i(rx_count),
    .rx_overrun_i(rx_ovr), .transmit_clock_i(lclk), .rxd_i(rxd), .txd_o(txd), .rts_o(rts),
    .receive_frame_end_irq_o(irq));
  hfc_line_model i_hfc_line_model (.pat_i(pat), .lclk_o(lclk), .rxd_o(rxd));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) if (rx_push) rxq.push_back(rx_data);
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic get_bits(output logic [31:0] q);
    for (int i = 0; i < 32; i++) begin
      @(posedge lclk);
      q[i] = txd;
    end
  endtask
  task automatic send_frame(input logic [7:0] ctrl);
    int n = 0;
    wr_reg(2'h0, ctrl);
    rd_reg(2'h1, v);
    rxq.delete();
    @(posedge clk);
    tx_data <= 8'h31;
    tx_valid <= 1'b1;
    for (int t = 0; t < 20000 && n < 3; t++) begin
      @(posedge clk);
      if (tx_take) begin
        n++;
        tx_data <= 8'h31 + 8'(n);
        tx_valid <= n < 3;
      end
    end
    chk(n, 3);
    if (n != 3) finish_test();
    repeat (1200) @(posedge clk);
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    finish_test();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd_reg(2'h1, v);
    chk(v, 8'h00);
    get_bits(b);
    chk(b, 32'hffffffff);
    get_bits(b);
    chk(b, 32'hffffffff);
    wr_reg(2'h0, 8'h24);
    get_bits(b);
    get_bits(b);
    chk(b, 32'h0);
    wr_reg(2'h0, 8'h60);
    get_bits(b);
    get_bits(b);
    chk(b, 32'h0);
    wr_reg(2'h0, 8'h00);
    get_bits(b);
    get_bits(b);
    f = 1'b0;
    for (int s = 0; s < 16; s++) if (b[s+:16] === 16'h7e7e) f = 1'b1;
    chk(f, 1'b1);
    for (int h = 1; h >= 0; h--) begin
      wr_reg(2'h2, {7'h0, h[0]});
      wr_reg(2'h0, 8'h22);
      repeat (2) @(negedge clk);
      chk(rts, h[0]);
      wr_reg(2'h0, 8'h20);
      repeat (2) @(negedge clk);
      chk(rts, 1'b0);
    end
    for (int c = 0; c < 4; c++) begin
      @(posedge clk);
      rx_count <= 3'(c);
      rd_reg(2'h1, v);
      chk(v[1:0], (c == 0) ? 2'h0 : (c == 1) ? 2'h1 : 2'h3);
    end
    @(posedge clk);
    rx_count <= 3'h0;
    repeat (2) begin
      @(posedge clk);
      rx_ovr <= 1'b1;
      @(posedge clk);
      rx_ovr <= 1'b0;
    end
    rd_reg(2'h1, v);
    chk(v, 8'h82);
    rd_reg(2'h1, v);
    chk(v, 8'h00);
    for (int k = 0; k < 2; k++) begin
      wr_reg(2'h0, k ? 8'h20 : 8'ha0);
      rd_reg(2'h1, v);
      repeat (2) @(posedge lclk);
      pat <= k ? 8'hff : 8'h00;
      get_bits(b);
      rd_reg(2'h1, v);
      chk(v[5], 1'b1);
    end
    wr_reg(2'h2, 8'h03);
    for (int k = 0; k < 3; k++) begin
      send_frame(fc[k]);
      chk(rts, 1'b0);
      if (k < 2) chk(irq, 1'b1);
      rd_reg(2'h1, v);
      chk({v[6], v[4]}, (k < 2) ? 2'h1 : 2'h2);
      @(negedge clk);
      chk(irq, 1'b0);
      if (k < 2) chk({rxq[0], rxq[1], rxq[2]}, 24'h313233);
    end
    finish_test();
  end
endmodule
